// ===== hw/phyrs_regs.sv
// Operation
// - latch signal lost until read or reset
// - latch pll lock error until read
// - latch false carrier on bad start delimiter
// - invalid symbol drives rx error, latches flag
// - halt symbol reported and latched
// - two idles in packet latch premature end
// - receive flags meaningless in 10base-t mode
// - negotiation complete zero while running or disabled
// - negotiation complete one once registers valid
// - signal detect follows receive signal in 100
// - jabber bit mirrors basic status jabber
// - remote fault mirrors basic status bit
// - link bit mirrors latching-low basic link
// - receive jabber latches flag, read clears
// - remote jabber takes no other action
// - auto polarity inhibit stops polarity correction
// - heartbeat inhibit suppresses collision test pulse
// - link loss inhibit forces link passed
// - polarity flag shows swapped receive pair
// - jabber inhibit skips transmit jabber check
// - squelch inhibit drops idle need for link
`timescale 1ns/1ps
module phyrs_regs
    import phyrs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    // management register port
    input  wire logic        mgmt_rd,
    input  wire logic        mgmt_wr,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_rvalid,
    // receive path events and levels
    input  wire logic        mode_100,
    input  wire logic        ev_signal_lost,
    input  wire logic        ev_lock_error,
    input  wire logic        ev_false_carrier,
    input  wire logic        ev_invalid_symbol,
    input  wire logic        ev_halt_symbol,
    input  wire logic        ev_premature_end,
    input  wire logic        ev_rx_jabber,
    input  wire logic        polarity_swapped,
    input  wire logic        rx_signal_present,
    // negotiation and basic status sources
    input  wire logic        nego_enable,
    input  wire logic        nego_finished,
    input  wire logic        nego_regs_valid,
    input  wire logic        basic_jabber,
    input  wire logic        basic_remote_fault,
    input  wire logic        basic_link,
    // toward the mac or repeater
    output logic             rx_error,
    output logic             halt_report,
    // 10base-t controls
    output logic             tx_jabber_check_en,
    output logic             auto_polarity_correct_en,
    output logic             collision_heartbeat_test_en,
    output logic             link_force_pass,
    output logic             link_needs_idle
);

    // ****************************************************************
    // decode
    // ****************************************************************
    logic        rd_qs;
    logic        rd_ops;
    logic        wr_ops;
    logic [5:0]  rx_events;
    logic [5:0]  rx_flags_r;
    logic [5:0]  rx_flags_nxt;
    logic        rjab_r;
    logic        rjab_nxt;
    logic        pol_r;
    logic        pol_nxt;
    logic [13:0] ops_ctrl_r;
    logic        nego_done;
    logic        sig_det;
    logic [15:0] qs_word;
    logic [15:0] ops_word;
    logic [15:0] rdata_nxt;
    logic        rx_error_r;
    logic        halt_report_r;

    assign rd_qs  = mgmt_rd && (mgmt_addr == QUICK_STATUS_ADDR);
    assign rd_ops = mgmt_rd && (mgmt_addr == TENBT_OPS_ADDR);
    assign wr_ops = mgmt_wr && (mgmt_addr == TENBT_OPS_ADDR);

    // ****************************************************************
    // latching-high receive flags
    // ****************************************************************
    // events are only taken in 100 mode; in 10 mode the flags hold until a quick status read clears them
    assign rx_events = {6{mode_100}} &
                       {ev_signal_lost,
                        ev_lock_error,
                        ev_false_carrier,
                        ev_invalid_symbol,
                        ev_halt_symbol,
                        ev_premature_end};

    // set wins over the read clear so no event is lost
    assign rx_flags_nxt = (rx_flags_r & ~{6{rd_qs}}) | rx_events;
    assign rjab_nxt     = (rjab_r & ~rd_ops) | ev_rx_jabber;
    assign pol_nxt      = (pol_r & ~rd_ops) | polarity_swapped;

    // ****************************************************************
    // live status bits
    // ****************************************************************
    // an enable that drops forces the bit low at once
    assign nego_done = nego_enable && nego_finished && nego_regs_valid;
    assign sig_det   = mode_100 && rx_signal_present;

    assign qs_word = {5'h00,
                      rx_flags_r,
                      nego_done,
                      sig_det,
                      basic_jabber,
                      basic_remote_fault,
                      basic_link};

    assign ops_word = {rjab_r, pol_r, ops_ctrl_r};

    assign rdata_nxt = rd_qs  ? qs_word  :
                       rd_ops ? ops_word : mgmt_rdata;

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_flags_r <= RX_FLAGS_RESET;
            rjab_r     <= 1'b0;
            pol_r      <= 1'b0;
        end else begin
            rx_flags_r <= rx_flags_nxt;
            rjab_r     <= rjab_nxt;
            pol_r      <= pol_nxt;
        end
    end

    // reserved bits are stored as written; the manager keeps them at default
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ops_ctrl_r <= OPS_CTRL_RESET;
        end else if (wr_ops) begin
            ops_ctrl_r <= mgmt_wdata[13:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata  <= RDATA_RESET;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rdata  <= rdata_nxt;
            mgmt_rvalid <= rd_qs || rd_ops;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_error_r    <= 1'b0;
            halt_report_r <= 1'b0;
        end else begin
            rx_error_r    <= mode_100 && ev_invalid_symbol;
            halt_report_r <= mode_100 && ev_halt_symbol;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rx_error    = rx_error_r;
    assign halt_report = halt_report_r;

    // remote jabber feeds nothing but its own flag
    assign tx_jabber_check_en          = ~ops_ctrl_r[OPS_JABBER_INH];
    assign auto_polarity_correct_en    = ~ops_ctrl_r[OPS_AUTO_POL_INH];
    assign collision_heartbeat_test_en = ~ops_ctrl_r[OPS_HEARTBEAT_INH];
    assign link_force_pass             = ops_ctrl_r[OPS_LINK_LOSS_INH];
    assign link_needs_idle             = ~ops_ctrl_r[OPS_SQUELCH_INH];

endmodule : phyrs_regs

// ===== hw/phyrs_pkg.sv
package phyrs_pkg;

    // ****************************************************************
    // register addresses on the management port
    // ****************************************************************
    localparam logic [4:0]  QUICK_STATUS_ADDR  = 5'h11;
    localparam logic [4:0]  TENBT_OPS_ADDR     = 5'h12;

    // ****************************************************************
    // quick status field positions
    // ****************************************************************
    localparam int          QS_SIGNAL_LOST     = 10;
    localparam int          QS_LOCK_ERROR      = 9;
    localparam int          QS_FALSE_CARRIER   = 8;
    localparam int          QS_INVALID_SYMBOL  = 7;
    localparam int          QS_HALT_SYMBOL     = 6;
    localparam int          QS_PREMATURE_END   = 5;
    localparam int          QS_NEGO_COMPLETE   = 4;
    localparam int          QS_SIGNAL_DETECT   = 3;
    localparam int          QS_JABBER          = 2;
    localparam int          QS_REMOTE_FAULT    = 1;
    localparam int          QS_LINK            = 0;

    // ****************************************************************
    // 10base-t operations field positions
    // ****************************************************************
    localparam int          OPS_REMOTE_JABBER  = 15;
    localparam int          OPS_POLARITY_REV   = 14;
    localparam int          OPS_RSVD_HI_TOP    = 13;
    localparam int          OPS_RSVD_HI_BOT    = 6;
    localparam int          OPS_JABBER_INH     = 5;
    localparam int          OPS_RSVD_ONE       = 4;
    localparam int          OPS_AUTO_POL_INH   = 3;
    localparam int          OPS_HEARTBEAT_INH  = 2;
    localparam int          OPS_LINK_LOSS_INH  = 1;
    localparam int          OPS_SQUELCH_INH    = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [13:0] OPS_CTRL_RESET     = 14'h0010;
    localparam logic [5:0]  RX_FLAGS_RESET     = 6'h00;
    localparam logic [15:0] RDATA_RESET        = 16'h0000;

endpackage : phyrs_pkg

// ===== test/phyrs_regs_asserts.sv
`timescale 1ns/1ps
module phyrs_regs_chk
    import phyrs_pkg::*;
(
    input wire logic        clock, rst_n, mgmt_rd, mgmt_wr, mgmt_rvalid, mode_100,
    input wire logic        ev_invalid_symbol, ev_halt_symbol, rx_error, halt_report,
    input wire logic        nego_enable, nego_finished, nego_regs_valid, rx_signal_present,
    input wire logic        basic_jabber, basic_remote_fault, basic_link,
    input wire logic        link_force_pass, tx_jabber_check_en,
    input wire logic [4:0]  mgmt_addr,
    input wire logic [15:0] mgmt_wdata, mgmt_rdata
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_rq; mgmt_rd && mgmt_addr == QUICK_STATUS_ADDR; endsequence
    sequence s_wo; mgmt_wr && mgmt_addr == TENBT_OPS_ADDR; endsequence
    property p_rv;
        mgmt_rd && (mgmt_addr == QUICK_STATUS_ADDR || mgmt_addr == TENBT_OPS_ADDR) |=> mgmt_rvalid;
    endproperty
    property p_rxe; mode_100 && ev_invalid_symbol |=> rx_error; endproperty
    property p_hlt; mode_100 && ev_halt_symbol |=> halt_report; endproperty
    property p_ngo;
        s_rq |=> mgmt_rdata[QS_NEGO_COMPLETE] == $past(nego_enable && nego_finished && nego_regs_valid);
    endproperty
    property p_sd; s_rq |=> mgmt_rdata[QS_SIGNAL_DETECT] == $past(mode_100 && rx_signal_present);
    endproperty
    property p_mir; s_rq |=> mgmt_rdata[2:0] == $past({basic_jabber, basic_remote_fault, basic_link});
    endproperty
    property p_lfp; s_wo |=> link_force_pass == $past(mgmt_wdata[OPS_LINK_LOSS_INH]); endproperty
    property p_jab; s_wo |=> tx_jabber_check_en != $past(mgmt_wdata[OPS_JABBER_INH]); endproperty
    property p_hold; !mgmt_wr |=> $stable(link_force_pass) && $stable(tx_jabber_check_en); endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    a_rxe: assert property (p_rxe) else $error("rx error missing");
    a_hlt: assert property (p_hlt) else $error("halt report missing");
    a_ngo: assert property (p_ngo) else $error("nego complete wrong");
    a_sd: assert property (p_sd) else $error("signal detect wrong");
    a_mir: assert property (p_mir) else $error("mirror bits wrong");
    a_lfp: assert property (p_lfp) else $error("link force wrong");
    a_jab: assert property (p_jab) else $error("jabber check wrong");
    a_hold: assert property (p_hold) else $error("control moved");
endmodule : phyrs_regs_chk
bind phyrs_regs phyrs_regs_chk phyrs_regs_chk_i (.*);

// ===== test/phyrs_sta_model.sv
`timescale 1ns/1ps
module phyrs_sta_model
    import phyrs_pkg::*;
(
    input  wire logic        clock,
    output logic             mgmt_rd,
    output logic             mgmt_wr,
    output logic      [4:0]  mgmt_addr,
    output logic      [15:0] mgmt_wdata,
    input  wire logic [15:0] mgmt_rdata,
    input  wire logic        mgmt_rvalid
);
    initial begin
        {mgmt_rd, mgmt_wr, mgmt_addr, mgmt_wdata} = '0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] dt);
        @(posedge clock);
        mgmt_wr    <= 1'b1;
        mgmt_addr  <= a;
        mgmt_wdata <= (a == TENBT_OPS_ADDR) ? ((dt & 16'hC02F) | 16'h0010) : dt;
        @(posedge clock);
        mgmt_wr    <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] dt, output logic ok);
        @(posedge clock);
        mgmt_rd   <= 1'b1;
        mgmt_addr <= a;
        @(posedge clock);
        mgmt_rd   <= 1'b0;
        ok = 1'b0;
        dt = 16'hFFFF;
        repeat (3) begin
            #1;
            if (mgmt_rvalid && !ok) begin
                ok = 1'b1;
                dt = mgmt_rdata;
            end
            @(posedge clock);
        end
    endtask : rd
endmodule : phyrs_sta_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb
    import phyrs_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        mgmt_rd, mgmt_wr, mgmt_rvalid, rx_error, halt_report, ok;
    logic        tx_jabber_check_en, auto_polarity_correct_en, collision_heartbeat_test_en;
    logic        link_force_pass, link_needs_idle;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, d;
    logic [6:0]  ev = '0;
    logic [8:0]  lv = '0;
    logic [8:0]  tbl [5] = '{9'h038, 9'h018, 9'h030, 9'h145, 9'h042};
    int          error_cnt = 0;
    int          n_compared = 0;
    wire  [15:0] ctl = {11'h000, tx_jabber_check_en, auto_polarity_correct_en,
                        collision_heartbeat_test_en, link_force_pass, link_needs_idle};
    phyrs_regs phyrs_regs_i (.clock(clock), .rst_n(rst_n), .mgmt_rd(mgmt_rd),
        .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .rx_error(rx_error),
        .halt_report(halt_report), .tx_jabber_check_en(tx_jabber_check_en),
        .auto_polarity_correct_en(auto_polarity_correct_en),
        .collision_heartbeat_test_en(collision_heartbeat_test_en),
        .link_force_pass(link_force_pass), .link_needs_idle(link_needs_idle),
        .mode_100(lv[8]), .polarity_swapped(lv[7]),
        .rx_signal_present(lv[6]), .nego_enable(lv[5]), .nego_finished(lv[4]),
        .nego_regs_valid(lv[3]), .basic_jabber(lv[2]), .basic_remote_fault(lv[1]),
        .basic_link(lv[0]), .ev_rx_jabber(ev[6]), .ev_signal_lost(ev[5]), .ev_lock_error(ev[4]),
        .ev_false_carrier(ev[3]), .ev_invalid_symbol(ev[2]), .ev_halt_symbol(ev[1]),
        .ev_premature_end(ev[0]));
    phyrs_sta_model phyrs_sta_model_i (.clock(clock), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid));
    function automatic logic [15:0] qs(input logic [8:0] v);
        return {11'h000, v[5] & v[4] & v[3], v[8] & v[6], v[2:0]};
    endfunction : qs
    task finish_test;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        phyrs_sta_model_i.rd(a, d, ok);
        chk("rvalid", {15'h0000, ok}, 16'h0001);
        chk("rdata", d, exp);
        if (!ok) finish_test();
    endtask : rdchk
    task automatic pulse(input logic [6:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 7'h00;
    endtask : pulse
    initial forever #20 clock = ~clock;
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(TENBT_OPS_ADDR, 16'h0010);
        chk("controls", ctl, 16'h001D);
        lv <= 9'h100;
        for (int i = 0; i < 6; i++) begin
            pulse(7'h01 << i);
            rdchk(QUICK_STATUS_ADDR, 16'h0020 << i);
            rdchk(QUICK_STATUS_ADDR, 16'h0000);
        end
        lv <= 9'h000;
        pulse(7'h3F);
        lv <= 9'h100;
        rdchk(QUICK_STATUS_ADDR, 16'h0000);
        fork
            rdchk(QUICK_STATUS_ADDR, 16'h0000);
            pulse(7'h04);
        join
        rdchk(QUICK_STATUS_ADDR, 16'h0080);
        foreach (tbl[i]) begin
            lv <= tbl[i];
            rdchk(QUICK_STATUS_ADDR, qs(tbl[i]));
        end
        phyrs_sta_model_i.wr(TENBT_OPS_ADDR, 16'hFFEF);
        chk("controls", ctl, 16'h0002);
        rdchk(TENBT_OPS_ADDR, 16'h003F);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        lv    <= 9'h080;
        pulse(7'h40);
        lv    <= 9'h000;
        rdchk(TENBT_OPS_ADDR, 16'hC010);
        rdchk(TENBT_OPS_ADDR, 16'h0010);
        chk("controls", ctl, 16'h001D);
        phyrs_sta_model_i.rd(5'h13, d, ok);
        chk("unmapped", {15'h0000, ok}, 16'h0000);
        finish_test();
    end
endmodule : tb
